//--- verilog/fws_pkg.sv
// Shared constants for the failsafe watchdog supervisor
package fws_pkg;
    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS     = 10;      // 100 MHz core clock
    localparam int unsigned TIMEOUT_PERIOD_US = 10000;   // Nominal timeout, 10 ms
    localparam int unsigned TIMEOUT_CYCLES    = TIMEOUT_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned DEBOUNCE_DIV      = 32;      // Debounce is timeout / 32
    localparam int unsigned DEBOUNCE_CYCLES   = TIMEOUT_CYCLES / DEBOUNCE_DIV;
    localparam int unsigned CLEAR_PULSE_NS    = 150;     // Least clear pulse width
    localparam int unsigned CLEAR_PULSE_CYC   = (CLEAR_PULSE_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;

    // ==========================================================
    // Synchroniser lanes and reset values
    // ==========================================================
    localparam int unsigned LANE_IN_HIGH   = 0;  // Input above input_high_threshold
    localparam int unsigned LANE_IN_WARN   = 1;  // Input above input_warn_threshold
    localparam int unsigned LANE_IN_RESET  = 2;  // Input above input_reset_threshold
    localparam int unsigned LANE_SUP_ON    = 3;  // Supply above supply_on_threshold
    localparam int unsigned LANE_SUP_OFF   = 4;  // Supply above supply_off_threshold
    localparam int unsigned LANE_CLEAR     = 5;  // timer_clear_n pin
    localparam int unsigned NUM_LANES      = 6;
    localparam int unsigned NUM_MON        = 3;  // Debounced input comparators
    localparam logic [5:0]  LANE_RST_VAL   = 6'h20; // Clear pin idles high
    localparam logic        WARN_RST_VAL   = 1'b1;  // Timeout warning inactive
    localparam logic        SAVE_RST_VAL   = 1'b0;  // Power fail warning active
    localparam logic        SYSRST_RST_VAL = 1'b0;  // System reset active

    // ==========================================================
    // Supervisor states
    // ==========================================================
    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,  // Supply not on, everything held
        ST_WAIT_IN = 3'b001,  // Supply on, waiting for input high
        ST_POR     = 3'b010,  // Power-on reset delay running
        ST_RUN     = 3'b011,  // Watchdog active
        ST_IN_RST  = 3'b100   // Input collapsed, waiting for input high
    } fws_state_t;
endpackage : fws_pkg

//--- verilog/fws_supervisor.sv
// Failsafe watchdog supervisor: supply sequencing, input monitor, watchdog
//
// Contract
// - Supply below on threshold holds reset, save low; code holds them only until supply first counts as on, then only below off
// - Supply below off threshold disables all, reset and save low, warning high
// - Input high starts timer; reset released after timeout
// - Input below warn drives save low until high
// - Input below reset level drives reset, halts timer
// - Input high after input reset restarts power-up
// - Power-up waits for supply on threshold
// - Timeout period nominally 10 ms
// - Input changes debounced timeout/32, then act promptly
// - Clear falling edge zeroes timer, warning high
// - Unserviced warning toggles; reset after first low phase
// - Clear pulses ignored during power-on reset delay
// - Input reset overrides timer; clears ignored until power-up
`timescale 1ns/1ps

module fws_supervisor #(
    parameter int unsigned TIMEOUT_CYCLES  = fws_pkg::TIMEOUT_CYCLES,
    parameter int unsigned DEBOUNCE_CYCLES = TIMEOUT_CYCLES / fws_pkg::DEBOUNCE_DIV
) (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_sys_rst,
    // Supply comparator levels
    input  wire logic i_supply_above_on,
    input  wire logic i_supply_above_off,
    // Monitored input comparator levels
    input  wire logic i_input_above_high,
    input  wire logic i_input_above_warn,
    input  wire logic i_input_above_reset,
    // Host service pin
    input  wire logic i_timer_clear_n,
    // Supervisor outputs, all active low
    output logic      o_timeout_warning_n,
    output logic      o_power_fail_warning_n,
    output logic      o_system_reset_n
);
    import fws_pkg::*;

    localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);
    localparam int unsigned DW = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [TW-1:0] TMR_LAST = TW'(TIMEOUT_CYCLES - 1);
    localparam logic [DW-1:0] DB_LAST  = DW'(DEBOUNCE_CYCLES - 1);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    // Debounce must be shorter than a timeout and at least one cycle
    if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES >= TIMEOUT_CYCLES) begin : g_bad_db
        $error("Debounce length must lie between one cycle and the timeout");
    end
    // A clear pulse must be at most half a timeout to be meaningful
    if (TIMEOUT_CYCLES < 2 * CLEAR_PULSE_CYC) begin : g_bad_to
        $error("Timeout too short for the least clear pulse");
    end

    // ==========================================================
    // Three-stage synchronisers
    // ==========================================================
    logic [NUM_LANES-1:0] sy1_q, sy1_d;   // First stage, read only by second
    logic [NUM_LANES-1:0] sy2_q, sy2_d;   // Second stage
    logic [NUM_LANES-1:0] sy3_q, sy3_d;   // Third stage
    logic [NUM_LANES-1:0] lvl_q, lvl_d;   // Accepted level after agreement

    // Next values: shift in, accept only where stages two and three agree
    always_comb begin
        sy1_d = {i_timer_clear_n, i_supply_above_off, i_supply_above_on,
                 i_input_above_reset, i_input_above_warn, i_input_above_high};
        sy2_d = sy1_q;
        sy3_d = sy2_q;
        lvl_d = (sy2_q & ~(sy2_q ^ sy3_q)) | (lvl_q & (sy2_q ^ sy3_q));
    end

    // Registers only
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sy1_q <= LANE_RST_VAL;
            sy2_q <= LANE_RST_VAL;
            sy3_q <= LANE_RST_VAL;
            lvl_q <= LANE_RST_VAL;
        end else begin
            sy1_q <= sy1_d;
            sy2_q <= sy2_d;
            sy3_q <= sy3_d;
            lvl_q <= lvl_d;
        end
    end

    // Clear edge seen after synchronisation
    logic clr_fall;                        // One-cycle falling edge of clear
    assign clr_fall = lvl_q[LANE_CLEAR] & ~lvl_d[LANE_CLEAR];

    // ==========================================================
    // Input debounce
    // ==========================================================
    // Each comparator must hold a new level for a whole debounce interval;
    // spikes shorter than that never reach the sequencer at all.
    logic [NUM_MON-1:0] flt_q, flt_d;           // Debounced comparator levels
    logic [DW-1:0]      dbc_q [NUM_MON];        // Per-lane stability counter
    logic [DW-1:0]      dbc_d [NUM_MON];

    // Next values of the debounce counters and filtered levels
    always_comb begin
        flt_d = flt_q;
        for (int i = 0; i < NUM_MON; i++) begin
            dbc_d[i] = '0;
            if (lvl_q[i] != flt_q[i]) begin
                // Level differs: count until the interval has passed
                if (dbc_q[i] == DB_LAST) begin
                    flt_d[i] = lvl_q[i];
                end else begin
                    dbc_d[i] = dbc_q[i] + 1'b1;
                end
            end
        end
    end

    // Registers only
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            flt_q <= '0;
            for (int i = 0; i < NUM_MON; i++) begin
                dbc_q[i] <= '0;
            end
        end else begin
            flt_q <= flt_d;
            for (int i = 0; i < NUM_MON; i++) begin
                dbc_q[i] <= dbc_d[i];
            end
        end
    end

    logic in_high, in_warn, in_rst;             // Debounced input above levels
    assign in_high = flt_q[LANE_IN_HIGH];
    assign in_warn = flt_q[LANE_IN_WARN];
    assign in_rst  = flt_q[LANE_IN_RESET];

    // ==========================================================
    // Supply qualification and sequencer
    // ==========================================================
    logic          sup_ok_q, sup_ok_d;          // Supply counted as on
    fws_state_t    st_q, st_d;                  // Sequencer state
    logic [TW-1:0] tmr_q, tmr_d;                // Timeout counter
    logic          to_n_q, to_n_d;              // Timeout warning output
    logic          save_n_q, save_n_d;          // Power fail warning output
    logic          rst_n_q, rst_n_d;            // System reset output

    // Next values: hysteresis on supply, then the state machine
    always_comb begin
        sup_ok_d = sup_ok_q;
        if (!lvl_q[LANE_SUP_OFF]) begin
            sup_ok_d = 1'b0;
        end else if (lvl_q[LANE_SUP_ON]) begin
            sup_ok_d = 1'b1;
        end
        st_d     = st_q;
        tmr_d    = tmr_q;
        to_n_d   = 1'b1;
        save_n_d = save_n_q;
        rst_n_d  = rst_n_q;
        if (!sup_ok_q) begin
            // Supply off: everything held regardless of the input
            st_d     = ST_OFF;
            tmr_d    = '0;
            save_n_d = 1'b0;
            rst_n_d  = 1'b0;
        end else begin
            unique case (st_q)
                ST_OFF, ST_WAIT_IN, ST_IN_RST: begin
                    // Waiting for the input to reach the high level
                    tmr_d    = '0;
                    save_n_d = 1'b0;
                    rst_n_d  = 1'b0;
                    if (in_high) begin
                        st_d     = ST_POR;
                        save_n_d = 1'b1;
                    end else if (st_q == ST_OFF) begin
                        st_d = ST_WAIT_IN;
                    end
                end
                ST_POR: begin
                    // Reset held; clear edges have no effect here
                    rst_n_d = 1'b0;
                    tmr_d   = tmr_q + 1'b1;
                    if (tmr_q == TMR_LAST) begin
                        st_d    = ST_RUN;
                        tmr_d   = '0;
                        rst_n_d = 1'b1;
                    end
                end
                ST_RUN: begin
                    to_n_d = to_n_q;
                    tmr_d  = tmr_q + 1'b1;
                    if (clr_fall) begin
                        tmr_d   = '0;
                        to_n_d  = 1'b1;
                        rst_n_d = 1'b1;
                    end else if (tmr_q == TMR_LAST) begin
                        tmr_d  = '0;
                        to_n_d = ~to_n_q;
                        if (!to_n_q) begin
                            rst_n_d = 1'b0;
                        end
                    end
                end
                default: begin
                    st_d = ST_OFF;
                end
            endcase
            // Warning level follows the input once the sequence started
            if (st_q == ST_POR || st_q == ST_RUN) begin
                if (!in_warn) begin
                    save_n_d = 1'b0;
                end else if (in_high) begin
                    save_n_d = 1'b1;
                end
                // Collapse of the input overrides the watchdog at once
                if (!in_rst) begin
                    st_d     = ST_IN_RST;
                    tmr_d    = '0;
                    to_n_d   = 1'b1;
                    save_n_d = 1'b0;
                    rst_n_d  = 1'b0;
                end
            end
        end
    end

    // Registers only
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sup_ok_q <= 1'b0;
            st_q     <= ST_OFF;
            tmr_q    <= '0;
            to_n_q   <= WARN_RST_VAL;
            save_n_q <= SAVE_RST_VAL;
            rst_n_q  <= SYSRST_RST_VAL;
        end else begin
            sup_ok_q <= sup_ok_d;
            st_q     <= st_d;
            tmr_q    <= tmr_d;
            to_n_q   <= to_n_d;
            save_n_q <= save_n_d;
            rst_n_q  <= rst_n_d;
        end
    end

    // Outputs come straight from flip-flops
    assign o_timeout_warning_n    = to_n_q;
    assign o_power_fail_warning_n = save_n_q;
    assign o_system_reset_n       = rst_n_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    supply_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !sup_ok_q |=> !o_system_reset_n && !o_power_fail_warning_n)
        else $error("Outputs not held low with supply off");

    supply_drop_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sup_ok_q && !lvl_q[LANE_SUP_OFF] |=> !sup_ok_q ##1 st_q == ST_OFF)
        else $error("Supply drop did not disable the supervisor");

    por_release_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        st_q == ST_POR && tmr_q == TMR_LAST && sup_ok_q && in_rst
        |=> st_q == ST_RUN && o_system_reset_n && tmr_q == '0)
        else $error("Reset not released after power-on delay");

    save_warn_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sup_ok_q && (st_q == ST_RUN || st_q == ST_POR) && !in_warn
        |=> !o_power_fail_warning_n)
        else $error("Save warning not asserted below warn level");

    input_reset_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sup_ok_q && st_q == ST_RUN && !in_rst
        |=> st_q == ST_IN_RST && !o_system_reset_n && o_timeout_warning_n)
        else $error("Input collapse did not override the timer");

    por_ignore_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        st_q == ST_POR && clr_fall && tmr_q != TMR_LAST |=> !o_system_reset_n)
        else $error("Clear pulse acted during power-on delay");

    clear_timer_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sup_ok_q && st_q == ST_RUN && clr_fall && in_rst
        |=> tmr_q == '0 && o_timeout_warning_n && o_system_reset_n)
        else $error("Clear edge did not restart the watchdog");

    wd_expire_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sup_ok_q && st_q == ST_RUN && !clr_fall && in_rst && tmr_q == TMR_LAST
        |=> o_timeout_warning_n != $past(o_timeout_warning_n)
            && o_system_reset_n == ($past(o_system_reset_n) && $past(o_timeout_warning_n)))
        else $error("Watchdog expiry did not toggle warning or assert reset");

    debounce_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        flt_q[LANE_IN_WARN] != $past(flt_q[LANE_IN_WARN])
        |-> $past(dbc_q[LANE_IN_WARN]) == DB_LAST)
        else $error("Input level accepted before debounce elapsed");
endmodule : fws_supervisor

//--- sim/fws_host_model.sv
// Behavioural host processor that services the watchdog clear pin
`timescale 1ns/1ps

module fws_host_model (
    // Clock
    input  wire logic       i_mclk,
    // Service request from the bench
    input  wire logic       i_serve,           // One-cycle request to service
    input  wire logic [7:0] i_delay,           // Cycles before the pulse starts
    // Pin towards the supervisor
    output logic            o_timer_clear_n    // Active low clear pulse
);
    import fws_pkg::*;

    // ==========================================================
    // Clear pulse generation
    // ==========================================================
    // Idle high so no false falling edge is seen after reset;
    // a request while a pulse runs is lost, as with a busy real host
    initial begin
        o_timer_clear_n = 1'b1;
        forever begin
            @(posedge i_mclk);
            if (i_serve) begin
                repeat (i_delay) @(posedge i_mclk);
                #1 o_timer_clear_n = 1'b0;
                // One cycle over the least width, the host may be slow too
                repeat (CLEAR_PULSE_CYC + 1) @(posedge i_mclk);
                #1 o_timer_clear_n = 1'b1;
            end
        end
    end
endmodule : fws_host_model

//--- sim/fws_supervisor_tb.sv
// Self-checking testbench for the failsafe watchdog supervisor
`timescale 1ns/1ps

module fws_supervisor_tb;
    import fws_pkg::*;

    // ==========================================================
    // Signals and bookkeeping
    // ==========================================================
    localparam int TMO_LEN = 256;              // Shortened timeout
    localparam int DBC_LEN = 8;                // Shortened debounce
    logic       i_mclk, i_sys_rst;             // Clock and reset
    logic       sup_on, sup_off;               // Supply comparator levels
    logic       in_high, in_warn, in_rst;      // Input comparator levels
    logic       serve;                         // Request to the host
    logic [7:0] dly;                           // Host response delay
    logic       clr_n;                         // Clear pin
    logic       warn_n, save_n, rst_n;         // Supervisor outputs
    int         fails, checks_done;            // Counters
    int         seed = 23;                     // Random seed
    logic [2:0] expq[$];                       // Expected {warn, save, reset}
    event       smp;                           // Sample request

    fws_supervisor #(.TIMEOUT_CYCLES(TMO_LEN), .DEBOUNCE_CYCLES(DBC_LEN)) dut (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_supply_above_on(sup_on), .i_supply_above_off(sup_off),
        .i_input_above_high(in_high), .i_input_above_warn(in_warn),
        .i_input_above_reset(in_rst), .i_timer_clear_n(clr_n),
        .o_timeout_warning_n(warn_n), .o_power_fail_warning_n(save_n),
        .o_system_reset_n(rst_n));

    fws_host_model host (.i_mclk(i_mclk), .i_serve(serve), .i_delay(dly),
                         .o_timer_clear_n(clr_n));

    // Free running 100 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // ==========================================================
    // Helper tasks
    // ==========================================================
    task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %b seen %b", what, exp, seen);
        end
    endtask : check

    // Inputs always move one small delay after the edge
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : step

    task automatic note(input logic [2:0] e);
        expq.push_back(e);
        ->smp;
    endtask : note

    // Bounded wait for one output bit; running out is a mismatch
    task automatic wait_out(input int b, input logic v, input int lim);
        logic [2:0] o;
        for (int k = 0; k < lim; k++) begin
            o = {warn_n, save_n, rst_n};
            if (o[b] === v) break;
            step(1);
        end
        o = {warn_n, save_n, rst_n};
        check("level", {2'b00, o[b]}, {2'b00, v});
    endtask : wait_out

    task automatic service(input logic [7:0] d);
        dly   = d;
        serve = 1'b1;
        step(1);
        serve = 1'b0;
    endtask : service

    task automatic set_in(input logic h, input logic w, input logic r);
        {in_high, in_warn, in_rst} = {h, w, r};
    endtask : set_in

    // Power-up from input high; a clear during the delay must not stretch it
    task automatic por();
        wait_out(1, 1'b1, 40);
        note(3'b110);
        step(30);
        service(8'h00);
        step(200);
        note(3'b110);
        wait_out(0, 1'b1, 40);
        note(3'b111);
    endtask : por

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // ==========================================================
    // Output watcher: compares each note against the outputs
    // ==========================================================
    always @(smp) begin
        while (expq.size() > 0)
            check("outputs", {warn_n, save_n, rst_n}, expq.pop_front());
    end

    // Watchdog of the run, well beyond the few thousand cycles needed
    initial begin
        repeat (20000) @(posedge i_mclk);
        fails++;
        finish_test();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        i_sys_rst = 1'b1;
        {sup_on, sup_off, serve, dly} = '0;
        set_in(1'b0, 1'b0, 1'b0);
        step(16);
        i_sys_rst = 1'b0;
        step(1);
        note(3'b100);
        // Input rises before the supply
        set_in(1'b1, 1'b1, 1'b1);
        step(40);
        note(3'b100);
        {sup_on, sup_off} = 2'b11;
        por();
        // Serviced in time with random host latency
        for (int i = 0; i < 6; i++) begin
            service(8'($unsigned($random(seed)) % 60));
            step(150);
            note(3'b111);
        end
        // Unserviced: warning low after one period, reset after the next;
        // the last clear landed at most 150 cycles ago, so stay short of expiry
        step(90);
        note(3'b111);
        wait_out(2, 1'b0, 140);
        note(3'b011);
        step(200);
        note(3'b011);
        wait_out(2, 1'b1, 80);
        note(3'b110);
        service(8'h00);
        wait_out(0, 1'b1, 40);
        note(3'b111);
        // Input below warn, a short glitch, then recovery only at high
        service(8'h00);
        set_in(1'b0, 1'b0, 1'b1);
        wait_out(1, 1'b0, 30);
        note(3'b101);
        set_in(1'b0, 1'b0, 1'b0);
        step(3);
        set_in(1'b0, 1'b0, 1'b1);
        step(20);
        note(3'b101);
        set_in(1'b0, 1'b1, 1'b1);
        step(30);
        note(3'b101);
        set_in(1'b1, 1'b1, 1'b1);
        wait_out(1, 1'b0 ^ 1'b1, 30);
        note(3'b111);
        // Input collapse overrides the timer and ignores service
        service(8'h00);
        step(30);
        set_in(1'b0, 1'b0, 1'b0);
        wait_out(0, 1'b0, 30);
        note(3'b100);
        service(8'h00);
        step(300);
        note(3'b100);
        set_in(1'b1, 1'b1, 1'b1);
        por();
        // Supply loss, hysteresis, then a fresh start
        sup_off = 1'b0;
        sup_on  = 1'b0;
        wait_out(1, 1'b0, 20);
        note(3'b100);
        sup_off = 1'b1;
        step(40);
        note(3'b100);
        sup_on = 1'b1;
        por();
        step(2);
        finish_test();
    end
endmodule : fws_supervisor_tb
